// ---- verilog/fcl_loader.sv ----
// Flash configuration loader: fetches a bitstream from flash and clocks it to a target.
// Assumes clk_sys at 200 MHz; target status pins are watched on the link clock clkLink.
//
// Contract
// - Flash fetch overlaps output; cost is the larger
// - Normal and page random access waits access time times clock plus one
// - Page mode: one random then fifteen 30 ns reads
// - Total cycles: overhead plus N times per-byte cost
// - 8-bit flash: one access per byte, overhead five
// - 16-bit flash: two bytes per access, overhead three
// - Quad burst: four cycles per byte, overhead 48
// - 8-bit burst: two cycles per byte, overhead 22x+8
// - 16-bit burst: byte per cycle, overhead 20x+8
// - Serial output: 8 or 16 cycles per byte
// - Parallel uncompressed per-byte cycles by width and ratio
// - Parallel compressed per-byte cycles by width and ratio
// - One to sixteen target clock pulses per period
module fcl_loader #(
    parameter int ACCESS_NS = 100,
    parameter int ADDR_W    = 24,
    parameter int CNT_W     = 32
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              clkLink,
    input  wire logic [7:0]        regAddr,
    input  wire logic [31:0]       regWdata,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output logic      [31:0]       regRdata,
    output logic      [ADDR_W-1:0] flashAddr,
    input  wire logic [15:0]       flashDataIn,
    output logic                   flashNce,
    output logic                   flashNoe,
    output logic                   flashClk,
    output logic                   flashNadv,
    output logic                   flashSck,
    output logic                   flashNcs,
    output logic      [7:0]        fpgaData,
    output logic                   fpgaDclk,
    input  wire logic              fpgaConfDone,
    input  wire logic              fpgaNstatus
);
    // Access cycle counts fixed at elaboration from the flash access time
    localparam int CACC_I = ACCESS_NS * fcl_pkg::CLK_MHZ / fcl_pkg::NS_PER_US
                            + fcl_pkg::ACCESS_EXTRA;
    localparam int CPAGE_I = fcl_pkg::PAGE_NS * fcl_pkg::CLK_MHZ / fcl_pkg::NS_PER_US;
    localparam int PSUM_I = CACC_I + fcl_pkg::PAGE_RUN * CPAGE_I;
    localparam logic [7:0]  CACC  = 8'(CACC_I);
    localparam logic [7:0]  CPAGE = 8'(CPAGE_I);
    localparam logic [15:0] OV_N8  = 16'(fcl_pkg::OVH_W8_MUL * CACC_I);
    localparam logic [15:0] OV_N16 = 16'(fcl_pkg::OVH_W16_MUL * CACC_I);
    localparam logic [15:0] OV_P8  = 16'(fcl_pkg::OVH_W8_MUL * PSUM_I / fcl_pkg::PAGE_SPAN);
    localparam logic [15:0] OV_P16 = 16'(fcl_pkg::OVH_W16_MUL * PSUM_I / fcl_pkg::PAGE_SPAN);
    localparam logic [15:0] OV_Q   = 16'(fcl_pkg::OVH_QUAD);
    localparam logic [15:0] OV_B8  = 16'(fcl_pkg::OVH_B8_MUL * CACC_I + fcl_pkg::OVH_BURST_ADD);
    localparam logic [15:0] OV_B16 = 16'(fcl_pkg::OVH_B16_MUL * CACC_I
                                         + fcl_pkg::OVH_BURST_ADD);

    // ---------------- Link domain: target status pins ----------------
    logic       lnkSync1_reg;
    logic       lnkSync2_reg;
    logic       lnkSeen_reg;
    logic       lnkDone_reg;
    logic       lnkStat1_reg;
    logic       lnkStat2_reg;
    logic       lnkStatSeen_reg;
    logic       lnkStat_reg;

    // Two-sample filter rejects a single-cycle glitch on the open-drain lines
    always_ff @(posedge clkLink or negedge rst_n) begin
        if (!rst_n) begin
            lnkSync1_reg    <= 1'b0;
            lnkSync2_reg    <= 1'b0;
            lnkSeen_reg     <= 1'b0;
            lnkDone_reg     <= 1'b0;
            lnkStat1_reg    <= 1'b1;
            lnkStat2_reg    <= 1'b1;
            lnkStatSeen_reg <= 1'b1;
            lnkStat_reg     <= 1'b1;
        end else begin
            lnkSync1_reg    <= fpgaConfDone;
            lnkSync2_reg    <= lnkSync1_reg;
            lnkSeen_reg     <= lnkSync2_reg;
            lnkStat1_reg    <= fpgaNstatus;
            lnkStat2_reg    <= lnkStat1_reg;
            lnkStatSeen_reg <= lnkStat2_reg;
            if (lnkSeen_reg == lnkSync2_reg) begin
                lnkDone_reg <= lnkSync2_reg;
            end
            if (lnkStatSeen_reg == lnkStat2_reg) begin
                lnkStat_reg <= lnkStat2_reg;
            end
        end
    end

    // Level crossing into the system domain
    logic       xDone1_reg;
    logic       xDone2_reg;
    logic       xStat1_reg;
    logic       xStat2_reg;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            xDone1_reg <= 1'b0;
            xDone2_reg <= 1'b0;
            xStat1_reg <= 1'b1;
            xStat2_reg <= 1'b1;
        end else begin
            xDone1_reg <= lnkDone_reg;
            xDone2_reg <= xDone1_reg;
            xStat1_reg <= lnkStat_reg;
            xStat2_reg <= xStat1_reg;
        end
    end

    // ---------------- Flash data pin synchroniser ----------------
    logic [15:0] fData1_reg;
    logic [15:0] fData2_reg;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fData1_reg <= 16'h0000;
            fData2_reg <= 16'h0000;
        end else begin
            fData1_reg <= flashDataIn;
            fData2_reg <= fData1_reg;
        end
    end

    // ---------------- Registers ----------------
    logic [fcl_pkg::CTRL_W-1:0] ctrl_reg;
    logic [CNT_W-1:0]           bytes_reg;
    logic [CNT_W-1:0]           total_reg;
    logic [CNT_W-1:0]           sent_reg;
    logic [31:0]                rdata_reg;
    fcl_pkg::fcl_state_t        state_reg;
    fcl_pkg::fcl_state_t        state_next;

    wire       runBit  = ctrl_reg[fcl_pkg::CTRL_RUN];
    wire [1:0] amode   = ctrl_reg[fcl_pkg::CTRL_AM_HI:fcl_pkg::CTRL_AM_LO];
    wire [1:0] wmode   = ctrl_reg[fcl_pkg::CTRL_WD_HI:fcl_pkg::CTRL_WD_LO];
    wire       comp    = ctrl_reg[fcl_pkg::CTRL_COMP];
    wire       serial  = ctrl_reg[fcl_pkg::CTRL_SER];
    wire       ratio2  = ctrl_reg[fcl_pkg::CTRL_R2];
    wire       isBurst = (amode == fcl_pkg::AM_BURST);
    wire       isPage  = (amode == fcl_pkg::AM_PAGE);
    wire       isQuad  = isBurst && (wmode == fcl_pkg::WD_4);
    wire       isW16   = (wmode == fcl_pkg::WD_16);
    wire       active  = (state_reg == fcl_pkg::ST_OVER) || (state_reg == fcl_pkg::ST_STREAM);

    wire selCtrl  = (regAddr == fcl_pkg::OFF_CTRL);
    wire selBytes = (regAddr == fcl_pkg::OFF_BYTES);
    wire selStat  = (regAddr == fcl_pkg::OFF_STATUS);
    wire selTotal = (regAddr == fcl_pkg::OFF_TOTAL);
    wire selSent  = (regAddr == fcl_pkg::OFF_SENT);

    wire [31:0] statusWord = {28'h0000000, xDone2_reg, state_reg == fcl_pkg::ST_FAIL,
                              state_reg == fcl_pkg::ST_DONE, active};
    wire [31:0] rdMux = selCtrl  ? {24'h000000, ctrl_reg} :
                        selBytes ? 32'(bytes_reg) :
                        selStat  ? statusWord :
                        selTotal ? 32'(total_reg) :
                        selSent  ? 32'(sent_reg) : 32'h00000000;

    // ---------------- Mode-dependent figures ----------------
    // Start-up overhead
    wire [15:0] ovTarget = isQuad  ? OV_Q :
                           isBurst ? (isW16 ? OV_B16 : OV_B8) :
                           isPage  ? (isW16 ? OV_P16 : OV_P8) :
                           (isW16 ? OV_N16 : OV_N8);

    // Output cost per byte in half cycles
    wire [5:0] hcPar = comp ? (ratio2 ? fcl_pkg::HC_C_R2 :
                               isBurst ? fcl_pkg::HC_CB_R1 :
                               isW16 ? fcl_pkg::HC_CW16_R1 : fcl_pkg::HC_CW8_R1) :
                       isBurst ? (ratio2 ? fcl_pkg::HC_BUR_R2 : fcl_pkg::HC_BUR_R1) :
                       isW16 ? (ratio2 ? fcl_pkg::HC_W16_R2 : fcl_pkg::HC_W16_R1) :
                       (ratio2 ? fcl_pkg::HC_W8_R2 : fcl_pkg::HC_W8_R1);
    wire [5:0] cfgHalf = serial ? (ratio2 ? fcl_pkg::HC_SER_R2 : fcl_pkg::HC_SER_R1)
                                : hcPar;

    // ---------------- Fetch engine ----------------
    logic [7:0]        fCnt_reg;
    logic [3:0]        pageIdx_reg;
    logic [3:0]        nib_reg;
    logic [15:0]       hold_reg;
    logic              holdValid_reg;
    logic [CNT_W-1:0]  fetched_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [15:0]       ovCnt_reg;
    logic              fClk_reg;
    logic              nadv_reg;

    wire [7:0] fPeriod = isQuad  ? fcl_pkg::PER_QUAD :
                         isBurst ? fcl_pkg::PER_BURST :
                         (isPage && (pageIdx_reg != 4'h0)) ? CPAGE :
                         CACC;
    // Fetch waits for the stream so overhead and per-byte cost add as stated
    wire        fetchOn   = (state_reg == fcl_pkg::ST_STREAM) && (fetched_reg < bytes_reg);
    wire        fEnd      = (fCnt_reg == fPeriod - 8'h01);
    wire        fCapture  = fetchOn && fEnd && !holdValid_reg;
    wire [15:0] fWord     = isQuad ? {8'h00, nib_reg, fData2_reg[3:0]} : fData2_reg;
    wire [CNT_W-1:0] fStep = isW16 ? CNT_W'(2) : CNT_W'(1);

    // ---------------- Output engine ----------------
    logic [15:0] shift_reg;
    logic        second_reg;
    logic        wordBusy_reg;
    logic [4:0]  oCnt_reg;
    logic        odd_reg;
    logic [7:0]  fpgaData_reg;
    logic        dclk_reg;

    wire [4:0] slotLen  = 5'(cfgHalf >> 1) + {4'h0, cfgHalf[0] & odd_reg};
    wire       slotEnd  = (oCnt_reg == slotLen - 5'h01);
    wire       streamOn = (state_reg == fcl_pkg::ST_STREAM);
    wire       lastOfWd = !isW16 || second_reg;
    wire       byteDone = streamOn && wordBusy_reg && slotEnd;
    wire       lastByte = byteDone && (sent_reg + CNT_W'(1) == bytes_reg);
    wire       takeWord = streamOn && holdValid_reg && (!wordBusy_reg || (byteDone && lastOfWd));
    wire [7:0] curByte  = second_reg ? shift_reg[15:8] : shift_reg[7:0];
    wire [4:0] bitIdx   = ratio2 ? (oCnt_reg >> 1) : oCnt_reg;
    // Parallel: one pulse per byte; serial ratio two: one per bit, up to sixteen per word; serial ratio one holds it high
    wire       strobe   = serial ? (ratio2 ? oCnt_reg[0] : 1'b1) : slotEnd;

    // ---------------- Sequencer ----------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            fcl_pkg::ST_IDLE:   if (runBit && bytes_reg != '0) state_next = fcl_pkg::ST_OVER;
            fcl_pkg::ST_OVER:   if (ovCnt_reg == ovTarget - 16'h0001) begin
                                    state_next = fcl_pkg::ST_STREAM;
                                end
            fcl_pkg::ST_STREAM: if (lastByte) state_next = fcl_pkg::ST_DONE;
            fcl_pkg::ST_DONE:   state_next = fcl_pkg::ST_DONE;
            fcl_pkg::ST_FAIL:   state_next = fcl_pkg::ST_FAIL;
            default:            state_next = fcl_pkg::ST_IDLE;
        endcase
        // Target reports an error: stop reading flash
        if (active && !xStat2_reg) begin
            state_next = fcl_pkg::ST_FAIL;
        end
        // Clearing the run bit holds the loader in reset
        if (!runBit) begin
            state_next = fcl_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg  <= fcl_pkg::CTRL_RESET;
            bytes_reg <= '0;
            rdata_reg <= 32'h00000000;
            state_reg <= fcl_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
            if (regWr && selCtrl) ctrl_reg <= regWdata[fcl_pkg::CTRL_W-1:0];
            if (regWr && selBytes) bytes_reg <= CNT_W'(regWdata);
            if (regRd) rdata_reg <= rdMux;
        end
    end

    // Cycle counters: counted from the release of the run bit
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            total_reg <= '0;
            ovCnt_reg <= 16'h0000;
        end else if (state_reg == fcl_pkg::ST_IDLE) begin
            total_reg <= '0;
            ovCnt_reg <= 16'h0000;
        end else if (active) begin
            total_reg <= total_reg + CNT_W'(1);
            ovCnt_reg <= ovCnt_reg + 16'h0001;
        end
    end

    // During the stream, fetch stalls only while a word waits unused
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fCnt_reg      <= 8'h00;
            pageIdx_reg   <= 4'h0;
            nib_reg       <= 4'h0;
            hold_reg      <= 16'h0000;
            holdValid_reg <= 1'b0;
            fetched_reg   <= '0;
            addr_reg      <= '0;
        end else if (!active) begin
            fCnt_reg      <= 8'h00;
            pageIdx_reg   <= 4'h0;
            holdValid_reg <= 1'b0;
            fetched_reg   <= '0;
            addr_reg      <= '0;
        end else begin
            if (fetchOn && !fEnd) fCnt_reg <= fCnt_reg + 8'h01;
            if (fetchOn && isQuad && fCnt_reg == fcl_pkg::QUAD_NIB_AT) begin
                nib_reg <= fData2_reg[3:0];
            end
            if (fCapture) begin
                fCnt_reg    <= 8'h00;
                hold_reg    <= fWord;
                fetched_reg <= fetched_reg + fStep;
                addr_reg    <= addr_reg + ADDR_W'(1);
                pageIdx_reg <= pageIdx_reg + 4'h1;
            end
            if (fCapture) begin
                holdValid_reg <= 1'b1;
            end else if (takeWord) begin
                holdValid_reg <= 1'b0;
            end
        end
    end

    // Output shifter: takes the next word as the last byte of the current one ends
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg    <= 16'h0000;
            second_reg   <= 1'b0;
            wordBusy_reg <= 1'b0;
            oCnt_reg     <= 5'h00;
            odd_reg      <= 1'b0;
            sent_reg     <= '0;
        end else if (!streamOn) begin
            wordBusy_reg <= 1'b0;
            oCnt_reg     <= 5'h00;
            odd_reg      <= 1'b0;
            if (state_reg == fcl_pkg::ST_IDLE) sent_reg <= '0;
        end else begin
            if (wordBusy_reg) oCnt_reg <= slotEnd ? 5'h00 : oCnt_reg + 5'h01;
            if (byteDone) begin
                sent_reg   <= sent_reg + CNT_W'(1);
                odd_reg    <= !odd_reg;
                second_reg <= isW16 && !second_reg;
            end
            if (takeWord) begin
                shift_reg    <= hold_reg;
                second_reg   <= 1'b0;
                wordBusy_reg <= 1'b1;
            end else if (byteDone && lastOfWd) begin
                wordBusy_reg <= 1'b0;
            end
        end
    end

    // Pins toward flash and target
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fpgaData_reg <= 8'h00;
            dclk_reg     <= 1'b0;
            fClk_reg     <= 1'b0;
            nadv_reg     <= 1'b1;
        end else begin
            fpgaData_reg <= serial ? {7'h00, curByte[bitIdx[2:0]]} : curByte;
            dclk_reg     <= streamOn && wordBusy_reg && strobe;
            // Flash clock at half the system rate while a burst is fetching
            fClk_reg     <= isBurst && fetchOn && !holdValid_reg && !fClk_reg;
            nadv_reg     <= !(isBurst && state_reg == fcl_pkg::ST_IDLE && state_next
                                == fcl_pkg::ST_OVER);
        end
    end

    assign regRdata  = rdata_reg;
    assign flashAddr = addr_reg;
    assign flashNce  = !(active && !isQuad);
    assign flashNoe  = !(active && !isQuad);
    assign flashClk  = fClk_reg;
    assign flashNadv = nadv_reg;
    assign flashSck  = fClk_reg;
    assign flashNcs  = !(active && isQuad);
    assign fpgaData  = fpgaData_reg;
    assign fpgaDclk  = dclk_reg;
endmodule

// ---- verilog/fcl_pkg.sv ----
// Constants shared by the flash configuration loader.
// Assumes a 200 MHz system clock and a register port with byte addresses.
package fcl_pkg;
    // Timing
    localparam int CLK_MHZ      = 200;
    localparam int NS_PER_US    = 1000;
    localparam int PAGE_NS      = 30;
    localparam int PAGE_RUN     = 15;
    localparam int PAGE_SPAN    = 16;
    localparam int ACCESS_EXTRA = 1;
    // Start-up overhead factors
    localparam int OVH_W8_MUL   = 5;
    localparam int OVH_W16_MUL  = 3;
    localparam int OVH_QUAD     = 48;
    localparam int OVH_B8_MUL   = 22;
    localparam int OVH_B16_MUL  = 20;
    localparam int OVH_BURST_ADD = 8;
    // Flash fetch periods in burst mode, cycles per word, and the cycle at which the quad nibble is captured
    localparam logic [7:0] PER_QUAD  = 8'h04;
    localparam logic [7:0] PER_BURST = 8'h02;
    localparam logic [7:0] QUAD_NIB_AT = 8'h01;
    // Output cost per byte in half cycles
    localparam logic [5:0] HC_SER_R1  = 6'h10;
    localparam logic [5:0] HC_SER_R2  = 6'h20;
    localparam logic [5:0] HC_BUR_R1  = 6'h02;
    localparam logic [5:0] HC_BUR_R2  = 6'h04;
    localparam logic [5:0] HC_W16_R1  = 6'h03;
    localparam logic [5:0] HC_W16_R2  = 6'h05;
    localparam logic [5:0] HC_W8_R1   = 6'h04;
    localparam logic [5:0] HC_W8_R2   = 6'h06;
    localparam logic [5:0] HC_CB_R1   = 6'h08;
    localparam logic [5:0] HC_CW16_R1 = 6'h09;
    localparam logic [5:0] HC_CW8_R1  = 6'h0A;
    localparam logic [5:0] HC_C_R2    = 6'h10;
    // Register map
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_BYTES  = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_TOTAL  = 8'h0C;
    localparam logic [7:0] OFF_SENT   = 8'h10;
    // Control fields
    localparam int CTRL_RUN   = 0;
    localparam int CTRL_AM_LO = 1;
    localparam int CTRL_AM_HI = 2;
    localparam int CTRL_WD_LO = 3;
    localparam int CTRL_WD_HI = 4;
    localparam int CTRL_COMP  = 5;
    localparam int CTRL_SER   = 6;
    localparam int CTRL_R2    = 7;
    localparam int CTRL_W     = 8;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [1:0] AM_NORMAL = 2'h0;
    localparam logic [1:0] AM_PAGE   = 2'h1;
    localparam logic [1:0] AM_BURST  = 2'h2;
    localparam logic [1:0] WD_4  = 2'h0;
    localparam logic [1:0] WD_8  = 2'h1;
    localparam logic [1:0] WD_16 = 2'h2;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'b00001,
        ST_OVER   = 5'b00010,
        ST_STREAM = 5'b00100,
        ST_DONE   = 5'b01000,
        ST_FAIL   = 5'b10000
    } fcl_state_t;
endpackage

// ---- verif/fcl_far_model.sv ----
// Far side of the loader: a parallel/quad flash and the target's status pins.
// Assumes the bench drives doneReq and failReq; status pins move on clkLink.
module fcl_far_model (
    input  wire logic        clk_sys,
    input  wire logic        clkLink,
    input  wire logic [23:0] flashAddr,
    input  wire logic        flashNce,
    input  wire logic        flashNcs,
    input  wire logic        doneReq,
    input  wire logic        failReq,
    output logic      [15:0] flashDataIn,
    output logic             fpgaConfDone,
    output logic             fpgaNstatus
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        flashDataIn  = 16'hA5C3;
        fpgaConfDone = 1'b0;
        fpgaNstatus  = 1'b1;
    end
    // Deselected flash toggles its bus so stale data can never look valid
    always @(posedge clk_sys) begin
        if (!flashNce || !flashNcs)
            flashDataIn <= {~flashAddr[7:0], flashAddr[7:0]};
        else
            flashDataIn <= ~flashDataIn;
    end
    always @(posedge clkLink) begin
        fpgaConfDone <= doneReq;
        fpgaNstatus  <= !failReq;
    end
endmodule

// ---- verif/fcl_loader_asserts.sv ----
// Port timing checks for the flash configuration loader.
// Assumes only the loader's own ports; bound below.
module fcl_loader_asserts #(parameter int ADDR_W = 24) (
    input wire logic              clk_sys,
    input wire logic              rst_n,
    input wire logic [7:0]        regAddr,
    input wire logic              regRd,
    input wire logic [31:0]       regRdata,
    input wire logic [ADDR_W-1:0] flashAddr,
    input wire logic              flashNce,
    input wire logic              flashNoe,
    input wire logic              flashClk,
    input wire logic              flashNadv,
    input wire logic              flashSck,
    input wire logic              flashNcs,
    input wire logic              fpgaDclk
);
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Serial ratio one holds the strobe high across bytes, so only its timing is checked
    a_dclk_span: assert property (fpgaDclk |-> $past(!flashNce || !flashNcs))
        else $error("target clock outside a load");
    a_sck_same: assert property (flashSck == flashClk)
        else $error("quad clock differs from burst clock");
    a_noe_tracks: assert property (flashNoe == flashNce)
        else $error("output enable not with chip enable");
    a_sel_excl: assert property (!(!flashNce && !flashNcs))
        else $error("both flash selects active");
    a_nadv_pulse: assert property ($fell(flashNadv) |=> flashNadv)
        else $error("address valid low too long");
    a_addr_step: assert property ($changed(flashAddr) |->
        (flashAddr == $past(flashAddr) + 1'h1) || (flashAddr == '0))
        else $error("flash address skipped");
    a_rd_unmapped: assert property (regRd && regAddr == 8'h14 |=> regRdata == 32'h0)
        else $error("unmapped read not zero");
    a_rd_holds: assert property (!regRd |=> $stable(regRdata))
        else $error("read data moved without read");
endmodule
bind fcl_loader fcl_loader_asserts #(.ADDR_W(ADDR_W)) u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .regAddr(regAddr), .regRd(regRd), .regRdata(regRdata), .flashAddr(flashAddr),
    .flashNce(flashNce), .flashNoe(flashNoe), .flashClk(flashClk), .flashNadv(flashNadv),
    .flashSck(flashSck), .flashNcs(flashNcs), .fpgaDclk(fpgaDclk));

// ---- verif/fcl_loader_test.sv ----
// Self-checking bench for the flash configuration loader.
// Assumes the far-side model and the bound checker are compiled first.
module fcl_loader_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int  NB    = 8;
    localparam int  CACC  = 100 * fcl_pkg::CLK_MHZ / fcl_pkg::NS_PER_US + fcl_pkg::ACCESS_EXTRA;
    localparam int  CPG   = fcl_pkg::PAGE_NS * fcl_pkg::CLK_MHZ / fcl_pkg::NS_PER_US;
    localparam real CPAGE = (CACC + fcl_pkg::PAGE_RUN * fcl_pkg::PAGE_NS * fcl_pkg::CLK_MHZ
                            / fcl_pkg::NS_PER_US) / 16.0;
    logic        clk_sys  = 1'b0;
    logic        clkLink  = 1'b0;
    logic        rst_n    = 1'b0;
    logic [7:0]  regAddr  = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic        regWr    = 1'b0;
    logic        regRd    = 1'b0;
    logic        doneReq  = 1'b0;
    logic        failReq  = 1'b0;
    logic [31:0] regRdata;
    logic [31:0] rv;
    logic [23:0] flashAddr;
    logic [15:0] flashDataIn;
    logic [7:0]  fpgaData;
    logic        flashNce, flashNoe, flashClk, flashNadv, flashSck, flashNcs;
    logic        fpgaDclk, fpgaConfDone, fpgaNstatus;
    int          n_fail   = 0;
    int          compares = 0;
    always #2.5 clk_sys = ~clk_sys;
    always #3.0 clkLink = ~clkLink;
    fcl_loader #(.ACCESS_NS(100)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .clkLink(clkLink),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .flashAddr(flashAddr), .flashDataIn(flashDataIn),
        .flashNce(flashNce), .flashNoe(flashNoe), .flashClk(flashClk), .flashNadv(flashNadv),
        .flashSck(flashSck), .flashNcs(flashNcs), .fpgaData(fpgaData), .fpgaDclk(fpgaDclk),
        .fpgaConfDone(fpgaConfDone), .fpgaNstatus(fpgaNstatus));
    fcl_far_model u_far (.clk_sys(clk_sys), .clkLink(clkLink), .flashAddr(flashAddr),
        .flashNce(flashNce), .flashNcs(flashNcs), .doneReq(doneReq), .failReq(failReq),
        .flashDataIn(flashDataIn), .fpgaConfDone(fpgaConfDone), .fpgaNstatus(fpgaNstatus));
    task automatic end_sim;
        $display("Counts: %0d compares, %0d mismatches", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask
    // Read data are registered on the strobe edge and held until the next read, so sample just past that edge
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 rv = regRdata;
    endtask
    task automatic cmp_eq(input logic [31:0] g, input logic [31:0] e, input string m);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t %s: got %h expected %h", $time, m, g, e);
        end
    endtask
    // Fractional costs alternate per byte, so totals get a small window
    task automatic cmp_near(input logic [31:0] g, input real e, input string m);
        compares++;
        if ($isunknown(g) || (real'(g) - e) > 8.0 || (e - real'(g)) > 8.0) begin
            n_fail++;
            $display("[ERR] %0t %s: got %0d expected about %0.2f", $time, m, g, e);
        end
    endtask
    task automatic load(input logic [7:0] c, input real ovh, input real cf, input real cc);
        int i;
        i = 0;
        rv = 32'h0;
        wr(fcl_pkg::OFF_BYTES, NB);
        wr(fcl_pkg::OFF_CTRL, {24'h0, c | 8'h01});
        while (rv[1] !== 1'b1 && i < 2000) begin
            rd(fcl_pkg::OFF_STATUS);
            i++;
        end
        if (i == 2000) begin
            n_fail++;
            end_sim();
        end
        rd(fcl_pkg::OFF_SENT);
        cmp_eq(rv, NB, "bytes sent");
        rd(fcl_pkg::OFF_TOTAL);
        cmp_near(rv, ovh + NB * ((cf > cc) ? cf : cc), "total cycles");
        wr(fcl_pkg::OFF_CTRL, 32'h0);
        $display("Load with control %h finished", c);
    endtask
    initial begin
        #400us;
        n_fail++;
        end_sim();
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(fcl_pkg::OFF_CTRL);
        cmp_eq(rv, 32'h0, "control reset value");
        wr(8'h14, 32'hFFFF_FFFF);
        rd(8'h14);
        cmp_eq(rv, 32'h0, "unmapped read");
        load(8'h08, 5.0 * CACC, CACC, 2.0);
        load(8'h90, 3.0 * CACC, CACC / 2.0, 2.5);
        // Eight words cover one random read and seven page reads, not the 16-word average
        load(8'h2A, 5.0 * CPAGE, (CACC + 7.0 * CPG) / 8.0, 5.0);
        load(8'h04, 48.0, 4.0, 1.0);
        load(8'h4C, 22.0 * CACC + 8.0, 2.0, 8.0);
        load(8'hD4, 20.0 * CACC + 8.0, 1.0, 16.0);
        load(8'h14, 20.0 * CACC + 8.0, 1.0, 1.0);
        load(8'hB4, 20.0 * CACC + 8.0, 1.0, 8.0);
        wr(fcl_pkg::OFF_BYTES, 32'h40);
        wr(fcl_pkg::OFF_CTRL, 32'h9);
        repeat (200) @(posedge clk_sys);
        failReq <= 1'b1;
        repeat (40) @(posedge clk_sys);
        rd(fcl_pkg::OFF_STATUS);
        cmp_eq({31'h0, rv[2]}, 32'h1, "error on target fault");
        rd(fcl_pkg::OFF_SENT);
        cmp_eq({31'h0, rv < 32'h40}, 32'h1, "stream stopped early");
        failReq <= 1'b0;
        wr(fcl_pkg::OFF_CTRL, 32'h0);
        doneReq <= 1'b1;
        repeat (20) @(posedge clk_sys);
        rd(fcl_pkg::OFF_STATUS);
        cmp_eq({31'h0, rv[3]}, 32'h1, "target done seen");
        $display("Fault and done tests finished");
        end_sim();
    end
endmodule
